// [rtl/dmac_arm_ctrl.sv]
// five-channel dma arm, abort, software request and bus arbitration control
`timescale 1ns/10ps
`default_nettype none
`include "dmac_map.svh"

// Summary of operation
// R1 - channel irq enable gates done interrupt
// R2 - eight-bit transfers may use seven length bits
// R3 - priority field decides cpu versus dma access
// R4 - abort bit stops selected channels, reads zero
// R5 - unarmed channel never transfers
// R6 - single and block modes disarm on completion
// R7 - request bit write acts as one trigger
// R8 - request bit clears when bus granted
// R9 - software stops running channel by disarming
// R10 - spare bits read zero or store harmlessly
// R11 - transfer mode code selects auto disarm
// R12 - trigger select zero means software only
// R13 - completion flag set on channel done
// R14 - writing zero to request bit ignored
module dmac_arm_ctrl #(
   parameter int FIFO_DEPTH = 8,
   parameter int TRIGGER_SELECT_W     = 32
) (
   // clock and reset
   input  wire logic                  REF_CLK,
   input  wire logic                  RST,
   // special function register port
   input  wire logic [7:0]            SFR_ADDR,
   input  wire logic                  SFR_WR,
   input  wire logic                  SFR_RD,
   input  wire logic [7:0]            SFR_WDATA,
   output var  logic [7:0]            SFR_RDATA,
   // per-channel descriptor fields
   input  wire logic [4:0]            CH_IRQ_ENABLE,
   input  wire logic [4:0]            CH_LEN7_MODE,
   input  wire logic [4:0]            CH_WORD_WIDTH_SELECT,
   input  wire logic [9:0]            CH_PRIORITY,
   input  wire logic [9:0]            CH_TRANSFER_MODE,
   input  wire logic [24:0]           CH_TRIGGER_SELECT,
   // hardware trigger events
   input  wire logic [TRIGGER_SELECT_W-1:0]     TRIGGER_IN,
   // memory bus arbitration
   input  wire logic                  CPU_MEM_REQ,
   output var  logic                  MEM_GO,
   output var  dmac_pkg::dmac_chan_t  MEM_CH,
   output var  logic                  BUSY,
   // transfer engine status
   input  wire logic                  XFER_DONE,
   input  wire logic                  FIRST_BYTE,
   output var  logic [7:0]            XFER_LEN,
   output var  logic [4:0]            ABORT_OUT,
   // completion flags and interrupts
   input  wire logic [4:0]            DONE_CLR,
   output var  logic [4:0]            DONE_FLAG,
   output var  logic [4:0]            CH_IRQ,
   // read data stream through the fifo
   input  wire logic [7:0]            MEM_RDATA,
   input  wire logic                  MEM_RVALID,
   output var  logic                  MEM_RREADY,
   output var  logic [7:0]            WR_DATA,
   output var  logic                  WR_VALID,
   input  wire logic                  WR_READY
);
   import dmac_pkg::*;

   localparam int NCH = `DMAC_NUM_CH;

   logic [7:0]  arm_r;         // arm register, bit 7 never stored
   logic [7:0]  arm_nxt;       // next arm register
   logic [4:0]  req_r;         // software request bits
   logic [4:0]  req_nxt;       // next request bits
   logic [4:0]  pend_r;        // latched hardware triggers
   logic [4:0]  pend_nxt;      // next latched triggers
   logic [4:0]  done_r;        // completion flags
   logic [4:0]  irq_r;         // interrupt pulses
   logic [4:0]  abort_r;       // abort pulses
   logic [7:0]  len_r;         // captured transfer length
   logic [7:0]  rdata_r;       // register read data
   logic        lost_r;        // guaranteed channel lost last try
   dmac_chan_t  cur_r;         // channel in service
   dmac_state_t state_r;       // control state
   dmac_state_t state_nxt;     // next control state
   dmac_chan_t  pick;          // lowest pending channel
   logic        any_cand;      // some channel ready to start

   wire         arm_wr;        // write to arm register
   wire         req_wr;        // write to request register
   wire         abort_wr;      // abort write
   wire  [4:0]  abort_vec;     // channels aborted this cycle
   wire  [4:0]  hw_hit;        // selected hardware trigger seen
   wire  [4:0]  cand;          // armed channels with work
   wire  [4:0]  cur_hot;       // one-hot of channel in service
   wire  [4:0]  done_vec;      // channel completing now
   wire  [4:0]  auto_clr;      // arm bits cleared by hardware
   wire  [4:0]  grant_vec;     // channel granted the bus now
   wire  [1:0]  cur_prio;      // priority of channel in service
   wire         active;        // a channel is being served
   wire         stop;          // service ended without completion
   wire         win;           // channel wins against the cpu

   dmac_stream_if #(.DW(8)) fill_if ();   // memory side of the fifo
   dmac_stream_if #(.DW(8)) drain_if ();  // writer side of the fifo

   // register decode
   assign arm_wr    = SFR_WR & (SFR_ADDR == `DMAC_ARM_ADDR);
   assign req_wr    = SFR_WR & (SFR_ADDR == `DMAC_REQ_ADDR);
   assign abort_wr  = arm_wr & SFR_WDATA[`DMAC_ABORT_BIT];
   assign abort_vec = abort_wr ? SFR_WDATA[4:0] : 5'h00;  // R4

   // service status
   assign active    = (state_r == DMAC_ACTIVE);
   assign cur_hot   = active ? (5'h01 << cur_r) : 5'h00;
   assign stop      = active & (~arm_r[cur_r] | abort_vec[cur_r]);  // R9
   assign done_vec  = (active & XFER_DONE & ~stop) ? cur_hot : 5'h00;
   assign cur_prio  = CH_PRIORITY[2*cur_r +: 2];

   // cpu loses when dma priority high, or guaranteed turn comes round
   assign win = ~CPU_MEM_REQ                                       // R3
              | (cur_prio[1])                                      // R3
              | ((cur_prio == `DMAC_PRIO_GUAR) & lost_r);          // R3
   assign MEM_GO    = active & ~stop & win & fill_if.ready;
   assign grant_vec = MEM_GO ? cur_hot : 5'h00;

   // per-channel trigger selection and mode decode
   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_ch
         wire [4:0] tsel = CH_TRIGGER_SELECT[5*i +: 5];
         wire [1:0] tmod = CH_TRANSFER_MODE[2*i +: 2];
         // code zero: software only; code one: previous channel done
         assign hw_hit[i] = (tsel == `DMAC_TSEL_NONE) ? 1'b0         // R12
                          : (tsel == `DMAC_TSEL_PREV)
                            ? done_vec[(i + NCH - 1) % NCH]
                            : TRIGGER_IN[tsel];
         // non-repeating modes drop the arm bit at completion
         assign auto_clr[i] = done_vec[i]                            // R6
                            & ((tmod == DMAC_TM_SINGLE)              // R11
                             | (tmod == DMAC_TM_BLOCK));             // R11
      end
   endgenerate

   // only armed channels collect hardware triggers or use any trigger; request bits set while unarmed
   assign cand     = arm_r[4:0] & (pend_r | req_r) & ~cur_hot;       // R5
   assign pend_nxt = arm_r[4:0] & (pend_r | hw_hit)                  // R5
                   & ~((state_nxt == DMAC_ACTIVE && !active)
                       ? (5'h01 << pick) : 5'h00);

   // lowest numbered candidate wins the start
   always_comb begin
      pick     = '0;
      any_cand = 1'b0;
      for (int k = NCH - 1; k >= 0; k--) begin
         if (cand[k]) begin
            pick     = dmac_chan_t'(k);
            any_cand = 1'b1;
         end
      end
   end

   // arm register next value: software write beats hardware clear
   always_comb begin
      arm_nxt = arm_r;
      arm_nxt[4:0] = arm_r[4:0] & ~auto_clr;                         // R6
      if (abort_wr) begin
         arm_nxt[4:0] = arm_r[4:0] & ~auto_clr & ~SFR_WDATA[4:0];    // R4
      end else if (arm_wr) begin
         arm_nxt = {1'b0, SFR_WDATA[6:0]};                           // R10
      end
      arm_nxt[`DMAC_ABORT_BIT] = 1'b0;                               // R4
   end

   // request bits: ones set, zeros ignored, grant clears, set wins
   assign req_nxt = (req_r & ~grant_vec)                             // R8
                  | (req_wr ? SFR_WDATA[4:0] : 5'h00);               // R7 R14

   // control state next value
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         DMAC_IDLE: begin
            if (any_cand) begin
               state_nxt = DMAC_ACTIVE;
            end
         end
         DMAC_ACTIVE: begin
            if (stop || XFER_DONE) begin
               state_nxt = DMAC_IDLE;
            end
         end
      endcase
   end

   // register state
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         arm_r   <= `DMAC_ARM_RESET;
         req_r   <= 5'h00;
         pend_r  <= 5'h00;
         state_r <= DMAC_IDLE;
         cur_r   <= '0;
      end else begin
         arm_r   <= arm_nxt;
         req_r   <= req_nxt;
         pend_r  <= pend_nxt;
         state_r <= state_nxt;
         if (!active && any_cand) begin
            cur_r <= pick;
         end
      end
   end

   // guaranteed priority: after one loss to the cpu the next try wins
   always_ff @(posedge REF_CLK) begin
      if (RST || !active) begin
         lost_r <= 1'b0;
      end else if (cur_prio == `DMAC_PRIO_GUAR && !stop) begin
         lost_r <= CPU_MEM_REQ & ~MEM_GO;                            // R3
      end
   end

   // completion flags and channel interrupts, set beats clear
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         done_r  <= 5'h00;
         irq_r   <= 5'h00;
         abort_r <= 5'h00;
      end else begin
         done_r  <= (done_r & ~DONE_CLR) | done_vec;                 // R13
         irq_r   <= done_vec & CH_IRQ_ENABLE;                        // R1
         abort_r <= abort_vec;                                       // R4
      end
   end

   // length byte capture for eight-bit variable length transfers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         len_r <= 8'h00;
      end else if (active && FIRST_BYTE && MEM_RVALID) begin
         if (CH_LEN7_MODE[cur_r] && !CH_WORD_WIDTH_SELECT[cur_r]) begin
            len_r <= {1'b0, MEM_RDATA[6:0]};                         // R2
         end else begin
            len_r <= MEM_RDATA;                                      // R2
         end
      end
   end

   // register read, spare request bits and abort bit read zero
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rdata_r <= 8'h00;
      end else if (SFR_RD) begin
         if (SFR_ADDR == `DMAC_ARM_ADDR) begin
            rdata_r <= {1'b0, arm_r[6:0]};                           // R4
         end else if (SFR_ADDR == `DMAC_REQ_ADDR) begin
            rdata_r <= {3'h0, req_r};                                // R10
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   // read data passes through the fifo; full fifo holds off grants
   assign fill_if.data   = MEM_RDATA;
   assign fill_if.valid  = MEM_RVALID;
   assign drain_if.ready = WR_READY;

   dmac_fifo #(
      .DW    (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk   (REF_CLK),
      .rst   (RST),
      .fill  (fill_if),
      .drain (drain_if)
   );

   // outputs
   assign MEM_RREADY = fill_if.ready;
   assign WR_DATA    = drain_if.data;
   assign WR_VALID   = drain_if.valid;
   assign MEM_CH     = cur_r;
   assign BUSY       = active;
   assign XFER_LEN   = len_r;
   assign ABORT_OUT  = abort_r;
   assign DONE_FLAG  = done_r;
   assign CH_IRQ     = irq_r;
   assign SFR_RDATA  = rdata_r;
endmodule
`default_nettype wire

// [rtl/dmac_fifo.sv]
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dmac_fifo #(
   parameter int DW    = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic     clk,
   input wire logic     rst,
   // fill side
   dmac_stream_if.snk   fill,
   // drain side
   dmac_stream_if.src   drain
);
   localparam int AW = $clog2(DEPTH);

   logic [DW-1:0] mem_r [DEPTH];   // storage words
   logic [AW-1:0] wp_r;            // write pointer
   logic [AW-1:0] rp_r;            // read pointer
   logic [AW:0]   cnt_r;           // words held
   wire           push;            // word accepted
   wire           pop;             // word handed on

   assign fill.ready  = (cnt_r != (AW+1)'(DEPTH));
   assign drain.valid = (cnt_r != '0);
   assign drain.data  = mem_r[rp_r];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   // storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= fill.data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// [rtl/dmac_map.svh]
// register addresses, field positions, reset values and codes of the dma control
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// special function register addresses
`define DMAC_ARM_ADDR      8'hd6
`define DMAC_REQ_ADDR      8'hd7

// arm register fields
`define DMAC_ABORT_BIT     7
`define DMAC_ARM_SPARE_HI  6
`define DMAC_ARM_SPARE_LO  5
`define DMAC_ARM_RESET     8'h00

// request register reset value
`define DMAC_REQ_RESET     8'h00

// channel count and field widths
`define DMAC_NUM_CH        5
`define DMAC_TSEL_W        5

// trigger select codes
`define DMAC_TSEL_NONE     5'h00
`define DMAC_TSEL_PREV     5'h01

// priority codes
`define DMAC_PRIO_LOW      2'h0
`define DMAC_PRIO_GUAR     2'h1

`endif

// [rtl/dmac_pkg.sv]
// types shared by the dma arm and request control
package dmac_pkg;
   typedef logic [2:0] dmac_chan_t;
   typedef enum logic [1:0] {
      DMAC_TM_SINGLE,
      DMAC_TM_BLOCK,
      DMAC_TM_REP_SINGLE,
      DMAC_TM_REP_BLOCK
   } dmac_transfer_mode_field_t;
   typedef enum {DMAC_IDLE, DMAC_ACTIVE} dmac_state_t;
endpackage

// [rtl/dmac_stream_if.sv]
// valid/ready byte stream between the control and its data fifo
`timescale 1ns/10ps
`default_nettype none
interface dmac_stream_if #(parameter int DW = 8);
   logic [DW-1:0] data;   // payload
   logic          valid;  // payload present
   logic          ready;  // sink can take it
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// [sim/dmac_arm_ctrl_sva.sv]
// assertions on the ports of the dma arm control
`timescale 1ns/10ps
`default_nettype none
`include "dmac_map.svh"
module dmac_arm_ctrl_sva (
   // clock, reset and register port
   input wire logic       REF_CLK,
   input wire logic       RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   // descriptor fields
   input wire logic [4:0] CH_IRQ_ENABLE,
   input wire logic [4:0] CH_LEN7_MODE,
   input wire logic [4:0] CH_WORD_WIDTH_SELECT,
   input wire logic [9:0] CH_PRIORITY,
   // bus, engine and status
   input wire logic       CPU_MEM_REQ,
   input wire logic       MEM_GO,
   input wire dmac_pkg::dmac_chan_t MEM_CH,
   input wire logic       BUSY,
   input wire logic       XFER_DONE,
   input wire logic       FIRST_BYTE,
   input wire logic [7:0] XFER_LEN,
   input wire logic [4:0] ABORT_OUT,
   input wire logic [4:0] DONE_FLAG,
   input wire logic [4:0] CH_IRQ,
   input wire logic [7:0] MEM_RDATA,
   input wire logic       MEM_RVALID,
   input wire logic       MEM_RREADY
);
   import dmac_pkg::*;
   wire logic [1:0] prio = CH_PRIORITY[2*MEM_CH +: 2]; // served priority
   wire logic g01 = BUSY && MEM_RREADY && CPU_MEM_REQ && !SFR_WR
      && prio == 2'h1; // guaranteed channel facing the cpu
   wire logic l7 = CH_LEN7_MODE[MEM_CH] && !CH_WORD_WIDTH_SELECT[MEM_CH];
   wire logic [7:0] len = l7 ? {1'b0, MEM_RDATA[6:0]} : MEM_RDATA;
   wire logic arm_wr = SFR_WR && SFR_ADDR == `DMAC_ARM_ADDR;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   chk_abort_pulse: assert property (arm_wr && SFR_WDATA[7] |=>
      ABORT_OUT == $past(SFR_WDATA[4:0])) else $error("abort pulse wrong");
   chk_abort_rd0: assert property (SFR_RD && SFR_ADDR == 8'hd6 |=>
      !SFR_RDATA[7]) else $error("abort bit read as one");
   chk_req_spare: assert property (SFR_RD && SFR_ADDR == 8'hd7 |=>
      SFR_RDATA[7:5] == 3'h0) else $error("request spare bits set");
   chk_irq_gate: assert property (CH_IRQ != 5'h00 |->
      $past(XFER_DONE) && (CH_IRQ & ~$past(CH_IRQ_ENABLE)) == 5'h00)
      else $error("irq not gated");
   chk_irq_raise: assert property (BUSY && XFER_DONE &&
      CH_IRQ_ENABLE[MEM_CH] |=> CH_IRQ[$past(MEM_CH)]) else $error("no irq");
   chk_done_flag: assert property (BUSY && XFER_DONE |=>
      DONE_FLAG[$past(MEM_CH)]) else $error("done flag missing");
   chk_cpu_wins: assert property (BUSY && CPU_MEM_REQ && prio == 2'h0
      |-> !MEM_GO) else $error("dma beat the cpu");
   chk_dma_wins: assert property (BUSY && MEM_RREADY && !SFR_WR &&
      !$past(arm_wr) && prio[1] |-> MEM_GO)
      else $error("dma lost at high priority");
   chk_guar_turn: assert property (g01 && !MEM_GO ##1 g01 |-> MEM_GO)
      else $error("guaranteed turn skipped");
   chk_len_cap: assert property (BUSY && FIRST_BYTE && MEM_RVALID |=>
      XFER_LEN == $past(len)) else $error("length byte wrong");
   cov_abort: cover property (arm_wr && SFR_WDATA[7]);
   cov_irq: cover property (CH_IRQ != 5'h00);
   cov_guar: cover property (g01 && !MEM_GO ##1 g01 && MEM_GO);
endmodule
bind dmac_arm_ctrl dmac_arm_ctrl_sva dmac_arm_ctrl_sva_inst (.REF_CLK, .RST,
   .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .CH_IRQ_ENABLE,
   .CH_LEN7_MODE, .CH_WORD_WIDTH_SELECT, .CH_PRIORITY, .CPU_MEM_REQ, .MEM_GO,
   .MEM_CH, .BUSY, .XFER_DONE, .FIRST_BYTE, .XFER_LEN, .ABORT_OUT,
   .DONE_FLAG, .CH_IRQ, .MEM_RDATA, .MEM_RVALID, .MEM_RREADY);
`default_nettype wire

// [sim/dmac_arm_ctrl_tb.sv]
// self-checking bench for the dma arm and request control
`timescale 1ns/10ps
`default_nettype none
`include "dmac_map.svh"
module dmac_arm_ctrl_tb;
   import dmac_pkg::*;
   // bench driven inputs
   logic        REF_CLK = 1'b0, RST = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0;
   logic        XFER_DONE = 1'b0, WR_READY = 1'b1, cpu_busy = 1'b1;
   logic [7:0]  SFR_ADDR = 8'h00, SFR_WDATA = 8'h00;
   logic [4:0]  CH_IRQ_ENABLE = 5'h00, CH_LEN7_MODE = 5'h00;
   logic [4:0]  DONE_CLR = 5'h00, CH_WORD_WIDTH_SELECT = 5'h00;
   logic [9:0]  CH_PRIORITY = 10'h0d8, CH_TRANSFER_MODE = 10'h364;
   logic [24:0] CH_TRIGGER_SELECT = 25'h0000040; // channel 1 on event 2
   logic [31:0] TRIGGER_IN = 32'h00000000;
   // design and model outputs
   logic [7:0]  SFR_RDATA, XFER_LEN, MEM_RDATA, WR_DATA;
   logic [4:0]  ABORT_OUT, DONE_FLAG, CH_IRQ;
   logic        CPU_MEM_REQ, MEM_GO, BUSY, FIRST_BYTE;
   logic        MEM_RVALID, MEM_RREADY, WR_VALID;
   dmac_chan_t  MEM_CH;
   int          err_total = 0, n_compared = 0, grants = 0, drains = 0;
   int          cycles = 0, g0, m;
   dmac_arm_ctrl dmac_arm_ctrl_inst (.REF_CLK, .RST, .SFR_ADDR, .SFR_WR,
      .SFR_RD, .SFR_WDATA, .SFR_RDATA, .CH_IRQ_ENABLE, .CH_LEN7_MODE,
      .CH_WORD_WIDTH_SELECT, .CH_PRIORITY, .CH_TRANSFER_MODE,
      .CH_TRIGGER_SELECT, .TRIGGER_IN, .CPU_MEM_REQ, .MEM_GO, .MEM_CH, .BUSY,
      .XFER_DONE, .FIRST_BYTE, .XFER_LEN, .ABORT_OUT, .DONE_CLR, .DONE_FLAG,
      .CH_IRQ, .MEM_RDATA, .MEM_RVALID, .MEM_RREADY, .WR_DATA, .WR_VALID,
      .WR_READY);
   dmac_cpu_model dmac_cpu_model_inst (.clk(REF_CLK), .rst(RST),
      .cpu_busy(cpu_busy), .go(MEM_GO), .ready(MEM_RREADY), .busy(BUSY),
      .cpu_req(CPU_MEM_REQ), .rdata(MEM_RDATA), .rvalid(MEM_RVALID),
      .first(FIRST_BYTE));
   initial forever #10 REF_CLK = ~REF_CLK;
   // grant and drain counts, and the hang limit
   always @(posedge REF_CLK) begin
      if (MEM_GO) grants++;
      if (WR_VALID && WR_READY) drains++;
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("mismatch at %0t: run did not finish", $time);
         stop_test();
      end
   end
   task automatic stop_test();
      $display("errors %0d compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one register write, strobe held for one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge REF_CLK);
      {SFR_WR, SFR_ADDR, SFR_WDATA} = {1'b1, a, d};
      @(negedge REF_CLK);
      SFR_WR = 1'b0;
   endtask
   // one register read, data looked at the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge REF_CLK);
      {SFR_RD, SFR_ADDR} = {1'b1, a};
      @(negedge REF_CLK);
      SFR_RD = 1'b0;
      chk(SFR_RDATA, e);
   endtask
   task automatic wait_busy(input logic v);
      for (int i = 0; i < 30 && BUSY !== v; i++) @(negedge REF_CLK);
      chk({7'h00, BUSY}, {7'h00, v});
   endtask
   task automatic pulse_trigger_select();
      @(negedge REF_CLK) TRIGGER_IN = 32'hffffffff;
      @(negedge REF_CLK) TRIGGER_IN = 32'h00000000;
   endtask
   task automatic done_pulse();
      @(negedge REF_CLK) XFER_DONE = 1'b1;
      @(negedge REF_CLK) XFER_DONE = 1'b0;
   endtask
   initial begin
      repeat (9) @(negedge REF_CLK);
      RST = 1'b0;
      rd(`DMAC_ARM_ADDR, `DMAC_ARM_RESET);
      rd(`DMAC_REQ_ADDR, `DMAC_REQ_RESET);
      rd(8'h10, 8'h00);
      wr(`DMAC_ARM_ADDR, 8'h61);
      rd(`DMAC_ARM_ADDR, 8'h61);
      // events reach neither unarmed nor software-only channels
      pulse_trigger_select();
      repeat (6) @(negedge REF_CLK);
      chk({7'h00, BUSY}, 8'h00);
      wr(`DMAC_ARM_ADDR, 8'h02);
      pulse_trigger_select();
      wait_busy(1'b1);
      wr(`DMAC_ARM_ADDR, 8'h82);
      chk({3'h0, ABORT_OUT}, 8'h02);
      rd(`DMAC_ARM_ADDR, 8'h00);
      wait_busy(1'b0);
      // guaranteed channel 2 against a cpu asking every cycle
      wr(`DMAC_ARM_ADDR, 8'h04);
      wr(`DMAC_REQ_ADDR, 8'h04);
      wait_busy(1'b1);
      chk({5'h00, MEM_CH}, 8'h02);
      g0 = grants;
      repeat (8) @(negedge REF_CLK);
      chk(8'(grants - g0), 8'h04);
      done_pulse();
      chk({6'h00, DONE_FLAG[2], CH_IRQ[2]}, 8'h02);
      rd(`DMAC_ARM_ADDR, 8'h04);
      // every transfer mode on software-started channel 0
      for (m = 0; m < 4; m++) begin
         CH_TRANSFER_MODE[1:0] = m[1:0];
         CH_IRQ_ENABLE[0] = m[0];
         CH_LEN7_MODE[0] = m[1];
         CH_WORD_WIDTH_SELECT[0] = &m[1:0];
         DONE_CLR = 5'h1f;
         wr(`DMAC_ARM_ADDR, 8'h01);
         DONE_CLR = 5'h00;
         wr(`DMAC_REQ_ADDR, 8'h01);
         wr(`DMAC_REQ_ADDR, 8'h00);
         wait_busy(1'b1);
         rd(`DMAC_REQ_ADDR, 8'h01);
         cpu_busy = 1'b0;
         repeat (3) @(negedge REF_CLK);
         rd(`DMAC_REQ_ADDR, 8'h00);
         chk(XFER_LEN, (m == 2) ? 8'h45 : 8'hc5);
         done_pulse();
         chk({6'h00, DONE_FLAG[0], CH_IRQ[0]}, {7'h01, m[0]});
         rd(`DMAC_ARM_ADDR, {7'h00, m[1]});
         wr(`DMAC_ARM_ADDR, 8'h00);
         cpu_busy = 1'b1;
      end
      // fill the fifo with its reader stalled, then disarm mid-run
      WR_READY = 1'b0;
      DONE_CLR = 5'h1f;
      wr(`DMAC_ARM_ADDR, 8'h08);
      DONE_CLR = 5'h00;
      wr(`DMAC_REQ_ADDR, 8'h08);
      g0 = grants;
      repeat (24) @(negedge REF_CLK);
      chk({MEM_RREADY, 7'(grants - g0)}, 8'h09);
      chk(WR_DATA, 8'hc5);
      wr(`DMAC_ARM_ADDR, 8'h00);
      wait_busy(1'b0);
      chk({3'h0, DONE_FLAG}, 8'h00);
      WR_READY = 1'b1;
      repeat (24) @(negedge REF_CLK);
      chk({7'h00, WR_VALID}, 8'h00);
      chk(8'(drains), 8'(grants));
      stop_test();
   end
endmodule
`default_nettype wire

// [sim/dmac_cpu_model.sv]
// cpu core and memory model competing with the dma for the memory bus
`timescale 1ns/10ps
`default_nettype none
module dmac_cpu_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // cpu activity and dma grant
   input  wire logic       cpu_busy,
   input  wire logic       go,
   input  wire logic       ready,
   input  wire logic       busy,
   output logic            cpu_req,
   // memory read data
   output logic [7:0]      rdata,
   output logic            rvalid,
   output logic            first
);
   logic [7:0] cnt_r;  // bytes handed over in this service
   logic [7:0] last_r; // last byte handed over
   assign cpu_req = cpu_busy;
   assign first = rvalid && cnt_r == 8'h00;
   // an idle data line never shows the stale byte
   assign rdata = rvalid ? 8'hc5 + cnt_r : ~last_r;
   // a granted read answers next cycle and waits for room
   always_ff @(posedge clk) begin
      if (rst) rvalid <= 1'b0;
      else if (go) rvalid <= 1'b1;
      else if (ready) rvalid <= 1'b0;
      if (rst) last_r <= 8'h00;
      else if (rvalid && ready) last_r <= rdata;
      if (rst || (!busy && !rvalid)) cnt_r <= 8'h00;
      else if (rvalid && ready) cnt_r <= cnt_r + 8'h01;
   end
endmodule
`default_nettype wire
